// file: core/adc_seq_defines.svh
`ifndef ADC_SEQ_DEFINES_SVH
`define ADC_SEQ_DEFINES_SVH

// Register byte addresses.
`define ADDR_RESULT_LOW 8'h78
`define ADDR_RESULT_HIGH 8'h79
`define ADDR_CTRL_A 8'h7a
`define ADDR_CTRL_B 8'h7b
`define ADDR_INPUT_SELECT 8'h7c
`define ADDR_PIN_DISABLE 8'h7e

// Field positions in control and status register A.
`define CTRL_A_ENABLE 7
`define CTRL_A_START 6
`define CTRL_A_AUTO 5
`define CTRL_A_DONE 4
`define CTRL_A_IRQ_EN 3

// Field position of the left adjust bit in the input select register.
`define INSEL_LEFT_ADJUST 5

// Reset values.
`define RESET_BYTE 8'h00
`define RESET_RESULT 10'h000

// Conversion lengths in converter clock cycles.
`define FIRST_CONV_CYCLES 5'h19
`define NORMAL_CONV_CYCLES 5'h0d

// Trigger source code for free running.
`define TRIG_FREE_RUN 3'h0

`endif

// file: core/adc_seq_pkg.sv
package adc_seq_pkg;

  // Register bus request from software.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // Sequencer states.
  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_IDLE = 3'b010,
    ST_CONV = 3'b100
  } seq_state_t;

endpackage : adc_seq_pkg

// file: core/adc_clock_prescaler.sv
`timescale 1ns/100ps
`default_nettype none
`include "adc_seq_defines.svh"

// Produces one-cycle converter clock ticks from the system clock.
module adc_clock_prescaler (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic [2:0] select_i,
  output logic tick_o
);

  // Free-running divider counter.
  logic [6:0] count_q;
  logic [6:0] count_d;
  logic tick_d;
  logic [6:0] limit;

  // Works out the terminal count for the chosen division factor.
  always_comb begin
    case (select_i)
      3'h0, 3'h1: limit = 7'h01;
      3'h2: limit = 7'h03;
      3'h3: limit = 7'h07;
      3'h4: limit = 7'h0f;
      3'h5: limit = 7'h1f;
      3'h6: limit = 7'h3f;
      default: limit = 7'h7f;
    endcase
    count_d = 7'h00;
    tick_d = 1'b0;
    if (run_i) begin
      if (count_q >= limit) begin
        tick_d = 1'b1;
      end else begin
        count_d = count_q + 7'h01;
      end
    end
  end

  // Registers the divider state.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_q <= 7'h00;
      tick_o <= 1'b0;
    end else begin
      count_q <= count_d;
      tick_o <= tick_d;
    end
  end

endmodule : adc_clock_prescaler
`default_nettype wire

// file: core/adc_sequencing_control.sv
`timescale 1ns/100ps
`default_nettype none
`include "adc_seq_defines.svh"

// Summary of operation
// - Enable powers up; clearing aborts conversion.
// - Single mode: each start write outside a running conversion converts.
// - First conversion 25 cycles, later 13.
// - Start bit reads busy; zero writes ignored.
// - Free running: start write begins first.
// - Auto trigger starts on selected rising edge.
// - Done flag set on completion, cleared.
// - Interrupt needs enable and global enable.
// - Prescaler divides system clock 2 to 128.
// - Low byte read locks until high read.
// - Left or right result byte layout.
// - Trigger source ignored without auto trigger.
// - Trigger source code selects flag input.
// - Source switch to set flag triggers.
// - Switching to free running never triggers.
// - Disable bit forces pin input zero.
// - Reference and channel load at conversion start and end.
// - Adjust bit changes presentation immediately.
module adc_sequencing_control (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic global_irq_enable_i,
  input wire logic irq_ack_i,
  input wire logic [6:0] trigger_flags_i,
  input wire logic [9:0] sample_i,
  input wire logic [7:0] pin_raw_i,
  output logic [7:0] pin_value_o,
  output logic [7:0] pin_buffer_off_o,
  output logic irq_o,
  output logic converter_power_o,
  output logic sample_strobe_o,
  output logic [1:0] reference_select_o,
  output logic [4:0] channel_select_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Register and state storage.
  ////////////////////////////////////////////////////////////////////////////

  // Bundled bus request.
  adc_seq_pkg::reg_req_t req;
  // Sequencer state.
  adc_seq_pkg::seq_state_t state_q, state_d;
  // Control fields of register A.
  logic enable_q, enable_d;
  logic auto_q, auto_d;
  logic done_q, done_d;
  logic irq_en_q, irq_en_d;
  logic [2:0] prescale_q, prescale_d;
  // Trigger source field of register B.
  logic [2:0] trig_sel_q, trig_sel_d;
  // Input select register as software sees it.
  logic [7:0] insel_q, insel_d;
  // Reference and channel latched for the running conversion.
  logic [1:0] ref_act_q, ref_act_d;
  logic [4:0] chan_act_q, chan_act_d;
  // Pin buffer disable bits.
  logic [7:0] pin_off_q, pin_off_d;
  // Stored result and lock.
  logic [9:0] result_q, result_d;
  logic lock_q, lock_d;
  // A result that waited for the lock to drop.
  logic [9:0] pend_q, pend_d;
  logic pend_valid_q, pend_valid_d;
  // Set until the first conversion after enabling has run.
  logic first_q, first_d;
  // Converter clock cycle counter.
  logic [4:0] cycles_q, cycles_d;
  // Selected trigger level of the previous cycle.
  logic trig_prev_q, trig_prev_d;
  // Registered outputs.
  logic [7:0] rdata_d;
  logic irq_d, strobe_d;
  logic [7:0] pin_value_d;
  // Converter clock tick.
  logic tick;
  // Decoded helpers.
  logic trig_now, start_req, wr_a, wr_start, finish;

  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  // Selects the trigger flag for a source code; code zero follows the done flag.
  function automatic logic pick_trigger(input logic [2:0] sel, input logic [6:0] flags, input logic done);
    if (sel == `TRIG_FREE_RUN) begin
      pick_trigger = done;
    end else begin
      pick_trigger = flags[sel - 3'h1];
    end
  endfunction : pick_trigger

  // Presents the result as the low or high byte under the adjust setting.
  function automatic logic [7:0] present(input logic [9:0] res, input logic left, input logic high);
    if (left) begin
      present = high ? res[9:2] : {res[1:0], 6'h00};
    end else begin
      present = high ? {6'h00, res[9:8]} : res[7:0];
    end
  endfunction : present

  ////////////////////////////////////////////////////////////////////////////
  // Converter clock.
  ////////////////////////////////////////////////////////////////////////////

  // Divides the system clock while the converter is powered.
  adc_clock_prescaler u_prescaler (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .run_i(enable_q),
    .select_i(prescale_q),
    .tick_o(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.
  ////////////////////////////////////////////////////////////////////////////

  // Computes every next value of the block.
  always_comb begin
    wr_a = req.wr && (req.addr == `ADDR_CTRL_A);
    wr_start = wr_a && req.wdata[`CTRL_A_START];
    enable_d = enable_q;
    auto_d = auto_q;
    irq_en_d = irq_en_q;
    prescale_d = prescale_q;
    trig_sel_d = trig_sel_q;
    insel_d = insel_q;
    pin_off_d = pin_off_q;
    done_d = done_q;
    state_d = state_q;
    first_d = first_q;
    cycles_d = cycles_q;
    ref_act_d = ref_act_q;
    chan_act_d = chan_act_q;
    result_d = result_q;
    lock_d = lock_q;
    pend_d = pend_q;
    pend_valid_d = pend_valid_q;
    strobe_d = 1'b0;
    rdata_d = 8'h00;
    finish = 1'b0;
    // Software register writes.
    if (wr_a) begin
      enable_d = req.wdata[`CTRL_A_ENABLE];
      auto_d = req.wdata[`CTRL_A_AUTO];
      irq_en_d = req.wdata[`CTRL_A_IRQ_EN];
      prescale_d = req.wdata[2:0];
    end
    if (req.wr && (req.addr == `ADDR_CTRL_B)) begin
      trig_sel_d = req.wdata[2:0];
    end
    if (req.wr && (req.addr == `ADDR_INPUT_SELECT)) begin
      insel_d = req.wdata;
    end
    if (req.wr && (req.addr == `ADDR_PIN_DISABLE)) begin
      pin_off_d = req.wdata;
    end
    trig_now = pick_trigger(trig_sel_d, trigger_flags_i, done_q);
    trig_prev_d = trig_now;
    start_req = wr_start || (auto_q && trig_now && !trig_prev_q &&
                !((trig_sel_d == `TRIG_FREE_RUN) && (trig_sel_q != `TRIG_FREE_RUN)));
    // Sequencer.
    case (state_q)
      adc_seq_pkg::ST_OFF: begin
        first_d = 1'b1;
        if (enable_d) begin
          if (start_req) begin
            state_d = adc_seq_pkg::ST_CONV;
            cycles_d = 5'h00;
            ref_act_d = insel_d[7:6];
            chan_act_d = insel_d[4:0];
          end else begin
            state_d = adc_seq_pkg::ST_IDLE;
          end
        end
      end
      adc_seq_pkg::ST_IDLE: begin
        if (start_req) begin
          state_d = adc_seq_pkg::ST_CONV;
          cycles_d = 5'h00;
          ref_act_d = insel_d[7:6];
          chan_act_d = insel_d[4:0];
        end
      end
      adc_seq_pkg::ST_CONV: begin
        if (tick) begin
          cycles_d = cycles_q + 5'h01;
          if (cycles_d == (first_q ? `FIRST_CONV_CYCLES : `NORMAL_CONV_CYCLES)) begin
            finish = 1'b1;
            first_d = 1'b0;
            strobe_d = 1'b1;
            ref_act_d = insel_d[7:6];
            chan_act_d = insel_d[4:0];
            cycles_d = 5'h00;
            if (!(auto_q && (trig_sel_q == `TRIG_FREE_RUN))) begin
              state_d = adc_seq_pkg::ST_IDLE;
            end
          end
        end
      end
      default: begin
        state_d = adc_seq_pkg::ST_OFF;
      end
    endcase
    if (!enable_d) begin
      state_d = adc_seq_pkg::ST_OFF;
    end
    if (req.rd && (req.addr == `ADDR_RESULT_LOW)) begin
      lock_d = 1'b1;
    end
    if (req.rd && (req.addr == `ADDR_RESULT_HIGH)) begin
      lock_d = 1'b0;
    end
    if (finish) begin
      if (lock_q) begin
        pend_d = sample_i;
        pend_valid_d = 1'b1;
      end else begin
        result_d = sample_i;
      end
    end else if (pend_valid_q && !lock_q) begin
      result_d = pend_q;
      pend_valid_d = 1'b0;
    end
    if (finish) begin
      done_d = 1'b1;
    end else if (irq_ack_i || (wr_a && req.wdata[`CTRL_A_DONE])) begin
      done_d = 1'b0;
    end
    // Read data, valid only in the cycle after the read strobe.
    if (req.rd) begin
      case (req.addr)
        `ADDR_RESULT_LOW: rdata_d = present(result_q, insel_q[`INSEL_LEFT_ADJUST], 1'b0);
        `ADDR_RESULT_HIGH: rdata_d = present(result_q, insel_q[`INSEL_LEFT_ADJUST], 1'b1);
        `ADDR_CTRL_A: rdata_d = {enable_q, (state_q == adc_seq_pkg::ST_CONV), auto_q, done_q, irq_en_q,
                                 prescale_q};
        `ADDR_CTRL_B: rdata_d = {5'h00, trig_sel_q};
        `ADDR_INPUT_SELECT: rdata_d = insel_q;
        `ADDR_PIN_DISABLE: rdata_d = pin_off_q;
        default: rdata_d = 8'h00;
      endcase
    end
    irq_d = done_d && irq_en_d && global_irq_enable_i;
    pin_value_d = pin_raw_i & ~pin_off_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State registers.
  ////////////////////////////////////////////////////////////////////////////

  // Registers all state and every output.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= adc_seq_pkg::ST_OFF;
      enable_q <= 1'b0;
      auto_q <= 1'b0;
      done_q <= 1'b0;
      irq_en_q <= 1'b0;
      prescale_q <= 3'h0;
      trig_sel_q <= 3'h0;
      insel_q <= `RESET_BYTE;
      pin_off_q <= `RESET_BYTE;
      ref_act_q <= 2'h0;
      chan_act_q <= 5'h00;
      result_q <= `RESET_RESULT;
      pend_q <= `RESET_RESULT;
      pend_valid_q <= 1'b0;
      lock_q <= 1'b0;
      first_q <= 1'b1;
      cycles_q <= 5'h00;
      trig_prev_q <= 1'b0;
      rdata_o <= `RESET_BYTE;
      irq_o <= 1'b0;
      sample_strobe_o <= 1'b0;
      pin_value_o <= `RESET_BYTE;
      pin_buffer_off_o <= `RESET_BYTE;
      converter_power_o <= 1'b0;
      reference_select_o <= 2'h0;
      channel_select_o <= 5'h00;
    end else begin
      state_q <= state_d;
      enable_q <= enable_d;
      auto_q <= auto_d;
      done_q <= done_d;
      irq_en_q <= irq_en_d;
      prescale_q <= prescale_d;
      trig_sel_q <= trig_sel_d;
      insel_q <= insel_d;
      pin_off_q <= pin_off_d;
      ref_act_q <= ref_act_d;
      chan_act_q <= chan_act_d;
      result_q <= result_d;
      pend_q <= pend_d;
      pend_valid_q <= pend_valid_d;
      lock_q <= lock_d;
      first_q <= first_d;
      cycles_q <= cycles_d;
      trig_prev_q <= trig_prev_d;
      rdata_o <= rdata_d;
      irq_o <= irq_d;
      sample_strobe_o <= strobe_d;
      pin_value_o <= pin_value_d;
      pin_buffer_off_o <= pin_off_d;
      converter_power_o <= enable_d;
      reference_select_o <= ref_act_d;
      channel_select_o <= chan_act_d;
    end
  end

endmodule : adc_sequencing_control
`default_nettype wire

// file: dv/adc_seq_assertions.sv
`timescale 1ns/100ps
`default_nettype none
`include "adc_seq_defines.svh"

// Watches the sequencer ports against software-visible behaviour.
module adc_seq_checker (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic global_irq_enable_i,
  input wire logic irq_ack_i,
  input wire logic [7:0] pin_raw_i,
  input wire logic [7:0] pin_value_o,
  input wire logic irq_o,
  input wire logic converter_power_o,
  input wire logic sample_strobe_o
);
  // Mirrors of the enable, interrupt enable and pin disable bits.
  logic en_h;
  logic ie_h;
  logic [7:0] dis_h;

  ////////////////////////////////////////////////////////////////
  // Software writes update the mirrors at the same edge as the block.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      en_h <= 1'b0;
      ie_h <= 1'b0;
      dis_h <= 8'h00;
    end else if (wr_i && addr_i == `ADDR_CTRL_A) begin
      en_h <= wdata_i[`CTRL_A_ENABLE];
      ie_h <= wdata_i[`CTRL_A_IRQ_EN];
    end else if (wr_i && addr_i == `ADDR_PIN_DISABLE) begin
      dis_h <= wdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  // A completion strobe is followed by a long quiet stretch.
  sequence s_quiet;
    !sample_strobe_o [*8];
  endsequence

  rd_idle_a: assert property (!rd_i |=> rdata_o == 8'h00) else $error("read data not zero");
  unmapped_zero_a: assert property (rd_i && addr_i == 8'h7d |=> rdata_o == 8'h00) else $error("unmapped read");
  power_follow_a: assert property (converter_power_o == en_h) else $error("power level");
  off_no_strobe_a: assert property (!converter_power_o [*2] |-> !sample_strobe_o) else $error("strobe off");
  irq_gate_a: assert property (irq_o |-> ie_h && $past(global_irq_enable_i)) else $error("irq gate");
  ack_clears_a: assert property (irq_ack_i ##1 !sample_strobe_o |-> !irq_o) else $error("irq after ack");
  pin_mask_a: assert property (pin_value_o == ($past(pin_raw_i) & ~dis_h)) else $error("pin mask");
  disable_read_a: assert property (rd_i && addr_i == 8'h7e |=> rdata_o == $past(dis_h)) else $error("disable rd");
  strobe_gap_a: assert property (sample_strobe_o |=> s_quiet) else $error("conversion too short");
endmodule : adc_seq_checker

bind adc_sequencing_control adc_seq_checker adc_seq_checker_i (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .global_irq_enable_i(global_irq_enable_i), .irq_ack_i(irq_ack_i), .pin_raw_i(pin_raw_i),
  .pin_value_o(pin_value_o), .irq_o(irq_o), .converter_power_o(converter_power_o),
  .sample_strobe_o(sample_strobe_o));
`default_nettype wire

// file: dv/tb_top.sv
`timescale 1ns/100ps
`default_nettype none

`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin failures++; \
  $display("mismatch t=%0t got %h exp %h", $time, (a), (e)); end end

// Self-checking bench for the conversion sequencer.
module tb_top;
  logic ref_clk_i = 0, rst_i = 1, wr = 0, rd = 0, gie = 0, ack = 0, irq, pwr, stb;
  logic [7:0] addr = 0, wd = 0, raw = 0, rdata, pv, pb, rv, d;
  logic [6:0] tf = 0;
  logic [9:0] smp = 0, o;
  logic [15:0] hl;
  logic [1:0] rs;
  logic [4:0] cs;
  int failures = 0, num_checks = 0, n, c;

  initial forever #5 ref_clk_i = ~ref_clk_i;

  adc_sequencing_control adc_sequencing_control_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr),
    .wdata_i(wd), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .global_irq_enable_i(gie), .irq_ack_i(ack),
    .trigger_flags_i(tf), .sample_i(smp), .pin_raw_i(raw), .pin_value_o(pv), .pin_buffer_off_o(pb),
    .irq_o(irq), .converter_power_o(pwr), .sample_strobe_o(stb), .reference_select_o(rs),
    .channel_select_o(cs));

  ////////////////////////////////////////////////////////////////
  // Prescale factor and byte layout expected for a code and a result.
  function automatic int dv(input int p);
    return p < 2 ? 2 : 1 << p;
  endfunction : dv

  function automatic logic [15:0] lay(input logic [9:0] s, input logic l);
    return l ? {s, 6'h00} : {6'h00, s};
  endfunction : lay

  task automatic conclude();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude

  // One-cycle register bus write and read.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk_i);
    addr <= a;
    wd <= v;
    wr <= 1'b1;
    @(posedge ref_clk_i);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a);
    @(posedge ref_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk_i);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask : rd_reg

  // Counts edges up to the next completion strobe, under a bound.
  task automatic wait_stb();
    do begin
      @(posedge ref_clk_i);
      #1 c++;
    end while (stb !== 1'b1 && c < 2000);
    if (c >= 2000) begin
      failures++;
      conclude();
    end
  endtask : wait_stb

  // Counts completion strobes over a fixed stretch.
  task automatic quiet();
    n = 0;
    repeat (100) begin
      @(posedge ref_clk_i);
      #1 n += int'(stb !== 1'b0);
    end
  endtask : quiet

  // Starts one conversion, clearing the old done flag, and times it.
  task automatic conv(input logic [7:0] ctl, input int t);
    smp <= 10'($urandom);
    wr_reg(8'h7a, ctl | 8'h50);
    rd_reg(8'h7a);
    `CHK(rv[6:4], {1'b1, ctl[5], 1'b0})
    c = 3;
    wait_stb();
    `CHK(c >= t * dv(ctl[2:0]) - dv(ctl[2:0]) && c <= t * dv(ctl[2:0]) + dv(ctl[2:0]) + 2, 1'b1)
  endtask : conv

  ////////////////////////////////////////////////////////////////
  initial begin
    n = $urandom(32'h4f0a);
    repeat (10) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    // Every register and an unmapped place read zero after reset.
    foreach (hl[i]) if (i < 7) begin
      rd_reg(8'h7e - 8'(i));
      `CHK(rv, 8'h00)
    end
    // Disabled pins read zero.
    repeat (4) begin
      d = 8'($urandom);
      raw <= 8'($urandom);
      wr_reg(8'h7e, d);
      repeat (2) @(posedge ref_clk_i);
      `CHK(pb, d)
      `CHK(pv, raw & ~d)
    end
    // First conversion is long, then every prescale code.
    conv(8'h80, 25);
    for (int p = 0; p < 8; p++) conv(8'h80 | 8'(p), 13);
    rd_reg(8'h7a);
    `CHK(rv, 8'h97)
    for (int l = 0; l < 2; l++) begin
      wr_reg(8'h7c, 8'(l) << 5);
      hl = lay(smp, l[0]);
      rd_reg(8'h78);
      `CHK(rv, hl[7:0])
      rd_reg(8'h79);
      `CHK(rv, hl[15:8])
    end
    // Low byte read locks both bytes against a new result.
    rd_reg(8'h78);
    o = smp;
    conv(8'h80, 13);
    rd_reg(8'h79);
    hl = lay(o, 1'b1);
    `CHK(rv, hl[15:8])
    rd_reg(8'h78);
    rd_reg(8'h79);
    hl = lay(smp, 1'b1);
    `CHK(rv, hl[15:8])
    // Interrupt gated by the global enable, cleared by acknowledge.
    gie <= 1'b1;
    conv(8'h88, 13);
    `CHK(irq, 1'b1)
    @(posedge ref_clk_i);
    ack <= 1'b1;
    @(posedge ref_clk_i);
    ack <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    `CHK(irq, 1'b0)
    gie <= 1'b0;
    conv(8'h88, 13);
    `CHK(irq, 1'b0)
    // Writing back a set done flag in a read-modify-write clears it.
    rd_reg(8'h7a);
    `CHK(rv[4], 1'b1)
    wr_reg(8'h7a, rv);
    rd_reg(8'h7a);
    `CHK(rv[4], 1'b0)
    // Reference and channel changes wait for the running conversion.
    wr_reg(8'h7a, 8'hd0);
    d = 8'($urandom) | 8'hc1;
    wr_reg(8'h7c, d);
    `CHK(pwr, 1'b1)
    `CHK({rs, cs}, 7'h00)
    c = 0;
    wait_stb();
    `CHK({rs, cs}, {d[7:6], d[4:0]})
    // Disable in mid-conversion aborts it.
    wr_reg(8'h7a, 8'hd0);
    repeat (10) @(posedge ref_clk_i);
    wr_reg(8'h7a, 8'h00);
    quiet();
    `CHK(n, 0)
    `CHK(pwr, 1'b0)
    rd_reg(8'h7a);
    `CHK(rv, 8'h00)
    // Trigger source is ignored while auto trigger is off.
    // auto trigger off
    wr_reg(8'h7b, 8'h01);
    wr_reg(8'h7a, 8'h80);
    tf <= 7'h01;
    quiet();
    `CHK(n, 0)
    tf <= 7'h00;
    // Each source code starts on its own flag only.
    for (int k = 1; k < 8; k++) begin
      wr_reg(8'h7b, 8'(k));
      wr_reg(8'h7a, 8'hb0);
      tf <= ~(7'h01 << (k - 1));
      rd_reg(8'h7a);
      `CHK(rv[6], 1'b0)
      tf <= 7'h7f;
      c = 0;
      wait_stb();
      `CHK(c < 60, 1'b1)
      tf <= 7'h00;
    end
    // Switching to a source whose flag is set is an edge.
    wr_reg(8'h7b, 8'h01);
    tf <= 7'h02;
    quiet();
    `CHK(n, 0)
    wr_reg(8'h7b, 8'h02);
    c = 0;
    wait_stb();
    `CHK(c < 40, 1'b1)
    tf <= 7'h00;
    // Switching to free running with the flag set starts nothing.
    wr_reg(8'h7b, 8'h00);
    quiet();
    `CHK(n, 0)
    wr_reg(8'h7a, 8'he0);
    c = 0;
    wait_stb();
    `CHK(c < 40, 1'b1)
    c = 0;
    wait_stb();
    `CHK(c >= 24 && c <= 30, 1'b1)
    wr_reg(8'h7a, 8'h00);
    conclude();
  end
endmodule : tb_top
`default_nettype wire
